//--- hdl/timer_pkg.sv
/*
 Constants of the sixteen-bit timer base counter: register indices, field positions,
 reset values and widths. Assumes a plain word-wide register port on the peripheral clock.
*/
package timer_pkg;
   localparam int unsigned DATA_W = 16;
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned N_MATCH = 3;
   localparam int unsigned DIV_W = 10;

   // register indices on the register port
   localparam logic [3:0] FIRST_CONTROL_REG = 4'h0;
   localparam logic [3:0] WAVE_CONTROL_REG  = 4'h1;
   localparam logic [3:0] FIFTH_CONTROL_REG = 4'h2;
   localparam logic [3:0] SIXTH_CONTROL_REG = 4'h3;
   localparam logic [3:0] EVENT_CONTROL_REG = 4'h4;
   localparam logic [3:0] STATUS_REG        = 4'h5;
   localparam logic [3:0] COUNT_REG         = 4'h6;
   localparam logic [3:0] CYCLE_LENGTH_REG  = 4'h7;
   localparam logic [3:0] MATCH_REG_BASE    = 4'h8;
   localparam logic [3:0] CYCLE_BUF_REG     = 4'hb;
   localparam logic [3:0] MATCH_BUF_BASE    = 4'hc;

   // field positions
   localparam int unsigned ENABLE_BIT       = 0;
   localparam int unsigned PRESCALE_LSB     = 1;
   localparam int unsigned PRESCALE_W       = 3;
   localparam int unsigned XFER_AT_ZERO_BIT = 0;
   localparam int unsigned SPLIT_BIT        = 1;
   localparam int unsigned DOWN_BIT         = 0;
   localparam int unsigned HOLD_BIT         = 1;
   localparam int unsigned EVT_COUNT_BIT    = 0;
   localparam int unsigned EVT_DIR_BIT      = 1;
   localparam int unsigned ST_ZERO_BIT      = 0;
   localparam int unsigned ST_CEIL_BIT      = 1;
   localparam int unsigned ST_MAX_BIT       = 2;
   localparam int unsigned ST_DOWN_BIT      = 3;
   localparam int unsigned FRESH_CYCLE_BIT  = 0;

   // reset values, zero point and masks
   localparam logic [15:0] COUNT_RESET = 16'h0000;
   localparam logic [15:0] CYCLE_RESET = 16'hffff;
   localparam logic [15:0] MATCH_RESET = 16'h0000;
   localparam logic [15:0] ZERO_POINT  = 16'h0000;
   localparam logic [15:0] FULL_MASK   = 16'hffff;
   localparam logic [15:0] HALF_MASK   = 16'h00ff;
endpackage : timer_pkg

//--- hdl/timer_prescaler.sv
/*
 Prescaler of the timer tick: divides the peripheral clock by 1..1024.
 Assumes i_choice is steady while running; a change restarts no phase.
*/
`timescale 1ns/100ps
module timer_prescaler #(
   parameter int unsigned DIV_W = timer_pkg::DIV_W
) (
   input  wire logic       i_clk,
   input  wire logic       i_arst_n,
   input  wire logic       i_run,
   input  wire logic [2:0] i_choice,
   output logic            o_tick
);
   logic [DIV_W-1:0] div_q;
   logic [DIV_W-1:0] mask;

   if (DIV_W < 10) begin : g_width_check
      $error("prescaler needs ten bits for divide by 1024");
   end

   function automatic logic [DIV_W-1:0] div_mask(input logic [2:0] c);
      unique case (c)
         3'h0: div_mask = DIV_W'(10'h000);
         3'h1: div_mask = DIV_W'(10'h001);
         3'h2: div_mask = DIV_W'(10'h003);
         3'h3: div_mask = DIV_W'(10'h007);
         3'h4: div_mask = DIV_W'(10'h00f);
         3'h5: div_mask = DIV_W'(10'h03f);
         3'h6: div_mask = DIV_W'(10'h0ff);
         3'h7: div_mask = DIV_W'(10'h3ff);
      endcase
   endfunction : div_mask

   assign mask = div_mask(i_choice);

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         div_q <= '0;
      end else if (!i_run) begin
         div_q <= '0;
      end else begin
         div_q <= div_q + DIV_W'(1);
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_tick <= 1'b0;
      end else begin
         o_tick <= i_run && ((div_q & mask) == mask);
      end
   end
endmodule : timer_prescaler

//--- hdl/timer_base.sv
/*
 Base counter of a sixteen-bit timer: count, cycle length, three match channels,
 double buffers with fresh flags, event count and direction, split mode.
 Assumes a register master on i_clk and event inputs from another domain.
*/
`timescale 1ns/100ps
// Operation
// - sixteen-bit count, ceiling, match, buffers, fresh flags
// - detect zero, all ones, ceiling
// - compare count with zero, ceiling, matches
// - hit effects appear one clock after the tick
// - tick from prescaler or events
// - fresh buffers load at transfer point unless held
// - program ceiling, then enable, then count
// - event input A counts instead of clock
// - count in selected direction
// - up at ceiling wraps to zero
// - down at zero reloads ceiling
// - software count write wins immediately
// - direction change accepted while running
// - fresh flags set on write, cleared at transfer
// - match and buffer both writable
// - unbuffered ceiling write acts at once
// - ceiling below count means wrap first
// - buffered ceiling moves only at transfer
// - split into two eight-bit counters
// - events steer direction too
// - overflow request and event on wrap
module timer_base (
   input  wire logic        i_clk,
   input  wire logic        i_arst_n,
   input  wire logic [3:0]  i_addr,
   input  wire logic [15:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   input  wire logic        i_event_a,
   input  wire logic        i_event_b,
   output logic      [15:0] o_rdata,
   output logic             o_overflow_irq,
   output logic             o_overflow_evt,
   output logic             o_overflow_hi_evt,
   output logic      [5:0]  o_match_evt
);
   logic        enable_q;
   logic [2:0]  prescale_choice_q;
   logic        xfer_at_zero_q;
   logic        split_q;
   logic        down_bit_q;
   logic        transfer_hold_bit_q;
   logic        count_event_input_a_enable_q;
   logic        dir_event_enable_q;
   logic [15:0] count_value_q;
   logic [15:0] count_value_d;
   logic [15:0] cycle_length_q;
   logic [15:0] cycle_length_buffer_q;
   logic [15:0] match_value_q  [3];
   logic [15:0] match_buffer_q [3];
   logic [3:0]  fresh_q;
   logic        eva_s1_q;
   logic        eva_s2_q;
   logic        eva_s3_q;
   logic        evb_s1_q;
   logic        evb_s2_q;
   logic        presc_tick;
   logic        tick;
   logic        down;
   logic        at_zero;
   logic        at_ceil;
   logic        at_max;
   logic        wrap;
   logic        hi_wrap;
   logic        xfer;
   logic [5:0]  match_hit;
   logic [15:0] rd_mux;
   logic [15:0] lo_next;
   logic [15:0] hi_next;
   logic [15:0] full_next;
   logic        count_wr;
   logic        cycle_wr;
   logic        cycle_buf_wr;

   function automatic logic wr_at(input logic [3:0] a);
      wr_at = i_wr && (i_addr == a);
   endfunction : wr_at

   // one counting step in a field masked by m; ceiling p already masked
   function automatic logic [15:0] step(input logic [15:0] c, input logic [15:0] p,
                                        input logic dn, input logic [15:0] m);
      if (dn) begin
         step = (c == timer_pkg::ZERO_POINT) ? p : ((c - 16'h0001) & m);
      end else begin
         step = (c == p) ? timer_pkg::ZERO_POINT : ((c + 16'h0001) & m);
      end
   endfunction : step

   // event pins come from another domain
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         eva_s1_q <= 1'b0;
         eva_s2_q <= 1'b0;
         eva_s3_q <= 1'b0;
         evb_s1_q <= 1'b0;
         evb_s2_q <= 1'b0;
      end else begin
         eva_s1_q <= i_event_a;
         eva_s2_q <= eva_s1_q;
         eva_s3_q <= eva_s2_q;
         evb_s1_q <= i_event_b;
         evb_s2_q <= evb_s1_q;
      end
   end

   timer_prescaler #(
      .DIV_W (timer_pkg::DIV_W)
   ) u_prescaler (
      .i_clk    (i_clk),
      .i_arst_n (i_arst_n),
      .i_run    (enable_q),
      .i_choice (prescale_choice_q),
      .o_tick   (presc_tick)
   );

   // rising edge of event A is one tick
   assign tick = enable_q && (count_event_input_a_enable_q ?
                 (eva_s2_q && !eva_s3_q) : presc_tick);
   assign down = dir_event_enable_q ? evb_s2_q : down_bit_q;

   assign at_max  = (count_value_q == timer_pkg::FULL_MASK);
   assign at_zero = split_q ? (count_value_q[7:0] == 8'h00)
                            : (count_value_q == timer_pkg::ZERO_POINT);
   assign at_ceil = split_q ? (count_value_q[7:0] == cycle_length_q[7:0])
                            : (count_value_q == cycle_length_q);
   assign wrap    = down ? at_zero : at_ceil;
   assign hi_wrap = split_q && (down ? (count_value_q[15:8] == 8'h00)
                                     : (count_value_q[15:8] == cycle_length_q[15:8]));
   assign xfer    = tick && !transfer_hold_bit_q && (xfer_at_zero_q ? at_zero : at_ceil);

   always_comb begin
      for (int n = 0; n < 3; n++) begin
         if (split_q) begin
            match_hit[n]   = (count_value_q[7:0] == match_value_q[n][7:0]);
            match_hit[n+3] = (count_value_q[15:8] == match_value_q[n][15:8]);
         end else begin
            match_hit[n]   = (count_value_q == match_value_q[n]);
            match_hit[n+3] = 1'b0;
         end
      end
   end

   assign lo_next   = step({8'h00, count_value_q[7:0]}, {8'h00, cycle_length_q[7:0]},
                           down, timer_pkg::HALF_MASK);
   assign hi_next   = step({8'h00, count_value_q[15:8]}, {8'h00, cycle_length_q[15:8]},
                           down, timer_pkg::HALF_MASK);
   assign full_next = step(count_value_q, cycle_length_q, down, timer_pkg::FULL_MASK);

   always_comb begin
      count_value_d = count_value_q;
      if (wr_at(timer_pkg::COUNT_REG)) begin
         count_value_d = i_wdata;
      end else if (tick) begin
         count_value_d = split_q ? {hi_next[7:0], lo_next[7:0]} : full_next;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         count_value_q <= timer_pkg::COUNT_RESET;
      end else begin
         count_value_q <= count_value_d;
      end
   end

   // control registers
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         enable_q                     <= 1'b0;
         prescale_choice_q            <= 3'h0;
         xfer_at_zero_q               <= 1'b0;
         split_q                      <= 1'b0;
         down_bit_q                   <= 1'b0;
         transfer_hold_bit_q          <= 1'b0;
         count_event_input_a_enable_q <= 1'b0;
         dir_event_enable_q           <= 1'b0;
      end else begin
         if (wr_at(timer_pkg::FIRST_CONTROL_REG)) begin
            enable_q          <= i_wdata[timer_pkg::ENABLE_BIT];
            prescale_choice_q <= i_wdata[timer_pkg::PRESCALE_LSB +: timer_pkg::PRESCALE_W];
         end
         if (wr_at(timer_pkg::WAVE_CONTROL_REG)) begin
            xfer_at_zero_q <= i_wdata[timer_pkg::XFER_AT_ZERO_BIT];
            split_q        <= i_wdata[timer_pkg::SPLIT_BIT];
         end
         if (wr_at(timer_pkg::FIFTH_CONTROL_REG)) begin
            down_bit_q          <= i_wdata[timer_pkg::DOWN_BIT];
            transfer_hold_bit_q <= i_wdata[timer_pkg::HOLD_BIT];
         end
         if (wr_at(timer_pkg::EVENT_CONTROL_REG)) begin
            count_event_input_a_enable_q <= i_wdata[timer_pkg::EVT_COUNT_BIT];
            dir_event_enable_q           <= i_wdata[timer_pkg::EVT_DIR_BIT];
         end
      end
   end

   // working ceiling: direct write at once, buffer only at transfer
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         cycle_length_q        <= timer_pkg::CYCLE_RESET;
         cycle_length_buffer_q <= timer_pkg::CYCLE_RESET;
      end else begin
         if (wr_at(timer_pkg::CYCLE_LENGTH_REG)) begin
            cycle_length_q <= i_wdata;
         end else if (xfer && fresh_q[timer_pkg::FRESH_CYCLE_BIT]) begin
            cycle_length_q <= cycle_length_buffer_q;
         end
         if (wr_at(timer_pkg::CYCLE_BUF_REG)) begin
            cycle_length_buffer_q <= i_wdata;
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         for (int n = 0; n < 3; n++) begin
            match_value_q[n]  <= timer_pkg::MATCH_RESET;
            match_buffer_q[n] <= timer_pkg::MATCH_RESET;
         end
      end else begin
         for (int n = 0; n < 3; n++) begin
            if (wr_at(timer_pkg::MATCH_REG_BASE + 4'(n))) begin
               match_value_q[n] <= i_wdata;
            end else if (xfer && fresh_q[n+1]) begin
               match_value_q[n] <= match_buffer_q[n];
            end
            if (wr_at(timer_pkg::MATCH_BUF_BASE + 4'(n))) begin
               match_buffer_q[n] <= i_wdata;
            end
         end
      end
   end

   // a buffer write in the transfer cycle keeps its flag set
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         fresh_q <= 4'h0;
      end else begin
         for (int n = 0; n < 4; n++) begin
            if (wr_at((n == 0) ? timer_pkg::CYCLE_BUF_REG
                               : timer_pkg::MATCH_BUF_BASE + 4'(n - 1))) begin
               fresh_q[n] <= 1'b1;
            end else if (xfer) begin
               fresh_q[n] <= 1'b0;
            end
         end
      end
   end

   // hits found on the current count leave one clock after the tick that sees them
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_overflow_irq    <= 1'b0;
         o_overflow_evt    <= 1'b0;
         o_overflow_hi_evt <= 1'b0;
         o_match_evt       <= 6'h00;
      end else begin
         o_overflow_irq    <= tick && wrap;
         o_overflow_evt    <= tick && wrap;
         o_overflow_hi_evt <= tick && hi_wrap;
         o_match_evt       <= tick ? match_hit : 6'h00;
      end
   end

   always_comb begin
      rd_mux = 16'h0000;
      unique case (i_addr)
         timer_pkg::FIRST_CONTROL_REG: rd_mux = {12'h000, prescale_choice_q, enable_q};
         timer_pkg::WAVE_CONTROL_REG:  rd_mux = {14'h0000, split_q, xfer_at_zero_q};
         timer_pkg::FIFTH_CONTROL_REG: rd_mux = {14'h0000, transfer_hold_bit_q, down_bit_q};
         timer_pkg::SIXTH_CONTROL_REG: rd_mux = {12'h000, fresh_q};
         timer_pkg::EVENT_CONTROL_REG:
            rd_mux = {14'h0000, dir_event_enable_q, count_event_input_a_enable_q};
         timer_pkg::STATUS_REG:        rd_mux = {12'h000, down, at_max, at_ceil, at_zero};
         timer_pkg::COUNT_REG:         rd_mux = count_value_q;
         timer_pkg::CYCLE_LENGTH_REG:  rd_mux = cycle_length_q;
         4'h8:                         rd_mux = match_value_q[0];
         4'h9:                         rd_mux = match_value_q[1];
         4'ha:                         rd_mux = match_value_q[2];
         timer_pkg::CYCLE_BUF_REG:     rd_mux = cycle_length_buffer_q;
         4'hc:                         rd_mux = match_buffer_q[0];
         4'hd:                         rd_mux = match_buffer_q[1];
         4'he:                         rd_mux = match_buffer_q[2];
         default:                      rd_mux = 16'h0000;
      endcase
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_rdata <= 16'h0000;
      end else begin
         o_rdata <= i_rd ? rd_mux : 16'h0000;
      end
   end

   // assertions need sampled nets; a function body would read live strobes
   assign count_wr     = wr_at(timer_pkg::COUNT_REG);
   assign cycle_wr     = wr_at(timer_pkg::CYCLE_LENGTH_REG);
   assign cycle_buf_wr = wr_at(timer_pkg::CYCLE_BUF_REG);

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);

   sequence up_ceiling_s;
      tick && !down && !split_q && at_ceil && !count_wr;
   endsequence
   sequence match0_hit_s;
      tick && match_hit[0];
   endsequence

   count_write_a: assert property (count_wr |=>
      count_value_q == $past(i_wdata))
      else $error("count write not taken at once");
   up_wrap_a: assert property (up_ceiling_s |=> count_value_q == 16'h0000)
      else $error("up count did not wrap to zero at ceiling");
   down_reload_a: assert property (tick && down && !split_q && at_zero &&
      !count_wr |=> count_value_q == $past(cycle_length_q))
      else $error("down count did not reload ceiling");
   up_step_a: assert property (tick && !down && !split_q && !at_ceil &&
      !count_wr |=> count_value_q == $past(count_value_q) + 16'h0001)
      else $error("up count step wrong");
   overflow_pulse_a: assert property (up_ceiling_s |=> o_overflow_evt && o_overflow_irq
      ##1 (!o_overflow_evt || $past(wrap)))
      else $error("overflow pulse missing or too long");
   match_next_a: assert property (match0_hit_s |=> o_match_evt[0])
      else $error("match event not on next cycle");
   fresh_set_a: assert property (cycle_buf_wr |=> fresh_q[0])
      else $error("fresh flag not set on buffer write");
   xfer_load_a: assert property (xfer && fresh_q[0] &&
      !cycle_wr |=> cycle_length_q == $past(cycle_length_buffer_q)
      && !fresh_q[0] || $past(cycle_buf_wr))
      else $error("buffered ceiling not moved at transfer");
   zero_xfer_a: assert property (tick && xfer_at_zero_q && !transfer_hold_bit_q &&
      at_zero && fresh_q[0] && !cycle_wr |=> cycle_length_q == $past(cycle_length_buffer_q))
      else $error("buffered ceiling not moved at zero point");
   hold_keep_a: assert property (transfer_hold_bit_q &&
      !cycle_wr |=> $stable(cycle_length_q))
      else $error("ceiling moved while transfers held");
   idle_still_a: assert property ((!enable_q && !count_wr) [*2]
      |-> $stable(count_value_q))
      else $error("count moved while disabled");
endmodule : timer_base

//--- dv/event_source.sv
/*
 Event-system stand-in: count pulses on event A, direction level on event B.
 Assumes the bench requests a pulse with one-cycle i_fire, spaced 8+ clocks.
*/
`timescale 1ns/100ps
module event_source (
   input  wire logic i_clk,
   input  wire logic i_arst_n,
   input  wire logic i_fire,
   input  wire logic i_down,
   output logic      o_event_a,
   output logic      o_event_b
);
   logic [2:0] hold_q;

   // held three clocks so a two-stage sync cannot miss it
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         hold_q <= 3'h0;
      end else if (i_fire) begin
         hold_q <= 3'h3;
      end else if (hold_q != 3'h0) begin
         hold_q <= hold_q - 3'h1;
      end
   end

   assign o_event_a = (hold_q != 3'h0);

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_event_b <= 1'b0;
      end else begin
         o_event_b <= i_down;
      end
   end
endmodule : event_source

//--- dv/timer_base_bench.sv
/*
 Self-checking bench of the timer base counter over its register port.
 Assumes one 25 MHz clock and an event source model on the event inputs.
*/
`timescale 1ns/100ps
module timer_base_bench;
   logic        i_clk    = 1'b0;
   logic        i_arst_n = 1'b0;
   logic [3:0]  i_addr   = 4'h0;
   logic [15:0] i_wdata  = 16'h0000;
   logic        i_wr     = 1'b0;
   logic        i_rd     = 1'b0;
   logic        fire     = 1'b0;
   logic        down     = 1'b0;
   logic        event_a;
   logic        event_b;
   logic [15:0] o_rdata;
   logic        o_overflow_irq;
   logic        o_overflow_evt;
   logic        o_overflow_hi_evt;
   logic [5:0]  o_match_evt;
   int          miscompares = 0;
   int          checks      = 0;
   int          n;
   logic [15:0] d;
   logic [15:0] cv [3] = '{16'h0000, 16'h0003, 16'hffff};
   logic [15:0] sv [3] = '{16'h0001, 16'h0002, 16'h0004};
   int          div [8] = '{1, 2, 4, 8, 16, 64, 256, 1024};

   always #20 i_clk = ~i_clk;

   timer_base i_timer_base (
      .i_clk(i_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .i_event_a(event_a), .i_event_b(event_b),
      .o_rdata(o_rdata), .o_overflow_irq(o_overflow_irq),
      .o_overflow_evt(o_overflow_evt), .o_overflow_hi_evt(o_overflow_hi_evt),
      .o_match_evt(o_match_evt));

   event_source i_event_source (
      .i_clk(i_clk), .i_arst_n(i_arst_n), .i_fire(fire), .i_down(down),
      .o_event_a(event_a), .o_event_b(event_b));

   task automatic end_sim();
      $display("checks %0d miscompares %0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge i_clk);
      i_addr  <= a;
      i_wdata <= v;
      i_wr    <= 1'b1;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      @(posedge i_clk);
      i_addr <= a;
      i_rd   <= 1'b1;
      @(posedge i_clk);
      i_rd <= 1'b0;
      #1 v = o_rdata;
   endtask : rd

   task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
      rd(a, d);
      chk(d, exp);
   endtask : rchk

   function automatic logic pick(input int s);
      case (s)
         0:       pick = o_overflow_irq;
         1:       pick = o_overflow_evt;
         2:       pick = o_overflow_hi_evt;
         default: pick = o_match_evt[s-3];
      endcase
   endfunction : pick

   // edges counted from the call until the chosen pulse is seen
   task automatic wait_for(input int s, output int k);
      k = 0;
      do begin
         @(posedge i_clk);
         #1 k++;
      end while (pick(s) !== 1'b1 && k < 10000);
      if (k >= 10000) begin
         miscompares++;
         end_sim();
      end
   endtask : wait_for

   // first wait aligns on a pulse, second one measures the period
   task automatic gap(input int s, input int exp);
      wait_for(s, n);
      wait_for(s, n);
      chk(16'(n), 16'(exp));
   endtask : gap

   task automatic pulse();
      @(posedge i_clk);
      fire <= 1'b1;
      @(posedge i_clk);
      fire <= 1'b0;
      repeat (10) @(posedge i_clk);
   endtask : pulse

   initial begin
      repeat (12) @(posedge i_clk);
      i_arst_n <= 1'b1;
      rchk(timer_pkg::COUNT_REG, timer_pkg::COUNT_RESET);
      rchk(timer_pkg::CYCLE_LENGTH_REG, timer_pkg::CYCLE_RESET);
      rchk(timer_pkg::SIXTH_CONTROL_REG, 16'h0000);
      rchk(timer_pkg::MATCH_REG_BASE, timer_pkg::MATCH_RESET);
      rchk(4'hf, 16'h0000);
      repeat (4) @(posedge i_clk);
      rchk(timer_pkg::COUNT_REG, 16'h0000);
      $display("test reset done");

      wr(timer_pkg::CYCLE_LENGTH_REG, 16'h0003);
      for (int i = 0; i < 3; i++) begin
         wr(timer_pkg::COUNT_REG, cv[i]);
         rchk(timer_pkg::COUNT_REG, cv[i]);
         rd(timer_pkg::STATUS_REG, d);
         chk(d & 16'h0007, sv[i]);
      end
      wr(timer_pkg::COUNT_REG, 16'h0000);
      $display("test points done");

      for (int c = 0; c < 8; c++) begin
         wr(timer_pkg::FIRST_CONTROL_REG, 16'((c << timer_pkg::PRESCALE_LSB) | 1));
         gap(0, 4 * div[c]);
         if (c == 0) gap(1, 4);
         wr(timer_pkg::FIRST_CONTROL_REG, 16'h0000);
      end
      $display("test prescale done");

      wr(timer_pkg::FIRST_CONTROL_REG, 16'h0001);
      wr(timer_pkg::FIFTH_CONTROL_REG, 16'h0001);
      gap(0, 4);
      rd(timer_pkg::STATUS_REG, d);
      chk(d & 16'h0008, 16'h0008);
      wr(timer_pkg::FIFTH_CONTROL_REG, 16'h0000);
      wr(timer_pkg::CYCLE_LENGTH_REG, 16'h00ff);
      wait_for(0, n);
      wr(timer_pkg::COUNT_REG, 16'h00f0);
      wait_for(0, n);
      chk(16'(n), 16'd16);
      wr(timer_pkg::COUNT_REG, 16'hfff0);
      wait_for(0, n);
      chk(16'(n), 16'd272);
      wr(timer_pkg::COUNT_REG, 16'h0010);
      wr(timer_pkg::CYCLE_LENGTH_REG, 16'h0020);
      wait_for(0, n);
      chk(16'(n), 16'd15);
      $display("test running done");

      wr(timer_pkg::FIRST_CONTROL_REG, 16'h0000);
      wr(timer_pkg::CYCLE_LENGTH_REG, 16'h0003);
      wr(timer_pkg::COUNT_REG, 16'h0000);
      wr(timer_pkg::CYCLE_BUF_REG, 16'h0007);
      rchk(timer_pkg::SIXTH_CONTROL_REG, 16'h0001);
      rchk(timer_pkg::CYCLE_LENGTH_REG, 16'h0003);
      wr(timer_pkg::FIRST_CONTROL_REG, 16'h0001);
      gap(0, 8);
      rchk(timer_pkg::SIXTH_CONTROL_REG, 16'h0000);
      rchk(timer_pkg::CYCLE_LENGTH_REG, 16'h0007);
      wr(timer_pkg::FIFTH_CONTROL_REG, 16'h0002);
      wr(timer_pkg::CYCLE_BUF_REG, 16'h000f);
      gap(0, 8);
      rchk(timer_pkg::SIXTH_CONTROL_REG, 16'h0001);
      wr(timer_pkg::FIFTH_CONTROL_REG, 16'h0000);
      gap(0, 16);
      $display("test buffer done");

      wr(timer_pkg::MATCH_REG_BASE, 16'h0005);
      rchk(timer_pkg::MATCH_REG_BASE, 16'h0005);
      wr(timer_pkg::MATCH_BUF_BASE, 16'h0009);
      rchk(timer_pkg::SIXTH_CONTROL_REG, 16'h0002);
      wait_for(0, n);
      wait_for(3, n);
      chk(16'(n), 16'd10);
      rchk(timer_pkg::MATCH_REG_BASE, 16'h0009);
      gap(3, 16);
      wr(timer_pkg::FIRST_CONTROL_REG, 16'h0007);
      wr(timer_pkg::WAVE_CONTROL_REG, 16'h0001);
      wr(timer_pkg::CYCLE_BUF_REG, 16'h0007);
      wait_for(0, n);
      rchk(timer_pkg::CYCLE_LENGTH_REG, 16'h000f);
      gap(0, 64);
      rchk(timer_pkg::CYCLE_LENGTH_REG, 16'h0007);
      rchk(timer_pkg::SIXTH_CONTROL_REG, 16'h0000);
      $display("test match done");

      wr(timer_pkg::FIRST_CONTROL_REG, 16'h0000);
      wr(timer_pkg::WAVE_CONTROL_REG, 16'h0002);
      wr(timer_pkg::CYCLE_LENGTH_REG, 16'h0301);
      wr(timer_pkg::COUNT_REG, 16'h0000);
      wr(timer_pkg::FIRST_CONTROL_REG, 16'h0001);
      gap(1, 2);
      gap(2, 4);
      gap(4, 2);
      gap(8, 4);
      wr(timer_pkg::FIRST_CONTROL_REG, 16'h0000);
      wr(timer_pkg::WAVE_CONTROL_REG, 16'h0000);
      $display("test split done");

      wr(timer_pkg::CYCLE_LENGTH_REG, 16'h0003);
      wr(timer_pkg::COUNT_REG, 16'h0000);
      wr(timer_pkg::EVENT_CONTROL_REG, 16'h0001);
      wr(timer_pkg::FIRST_CONTROL_REG, 16'h0001);
      repeat (5) pulse();
      rchk(timer_pkg::COUNT_REG, 16'h0001);
      @(posedge i_clk);
      down <= 1'b1;
      wr(timer_pkg::EVENT_CONTROL_REG, 16'h0003);
      repeat (2) pulse();
      rchk(timer_pkg::COUNT_REG, 16'h0003);
      $display("test events done");
      end_sim();
   end
endmodule : timer_base_bench
